// *** src/phy_10m_test_and_bist_ctrl.sv ***
// Test, heartbeat, jabber and packet self-test control with an AXI4-Lite register slave
// Functional notes
// - Heartbeat disable bit acts in 10 Mb half duplex; one turns heartbeat off
// - At 100 Mb or full duplex the bit is ignored and heartbeat stays off
// - Jabber disable acts only at 10 Mb; one disables jabber, zero keeps it
// - Bits 15:8 read-only count errored received nibbles during self-test
// - Error count clears on self-test restart and saturates at its maximum
// - Bit 5 makes self-test transmit pseudo-random data without any break
// - Bit 4 enables the 10 Mb test pattern; choice matters only while set
// - Bit 2 selects the gap between test sequences: one 15 us, zero 10 us
// - Choice 00/01 data with end marker one/two, 10 link pulses, 11 ones
`timescale 1ns/1ns
module phy_10m_test_and_bist_ctrl
   import phy_test_pkg::*;
#(
   parameter int unsigned SEQ_CYC = SEQ_CYC_DEF,
   parameter int unsigned CNT_W   = 8
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        speed_100,
   input  wire logic        full_duplex,
   input  wire logic        selftest_restart,
   input  wire logic        nibble_error,
   output logic             heartbeat_en,
   output logic             jabber_en,
   output logic             selftest_nonstop_tx,
   output logic             pattern_send,
   output pattern_e         pattern_kind,
   output logic             irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GAP} gen_state_e;

   localparam logic [7:0] ADDR_TBT  = 8'(TBT_IDX * 4);
   localparam logic [7:0] ADDR_EXT  = 8'(EXT_IDX * 4);
   localparam logic [7:0] ADDR_STAT = 8'(IRQ_STAT_IDX * 4);
   localparam logic [7:0] ADDR_MASK = 8'(IRQ_MASK_IDX * 4);

   logic                 awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]           bresp_q, rresp_q;
   logic [31:0]          rdata_q;
   logic                 aw_held_q, w_held_q;
   logic [7:0]           aw_addr_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 aw_take, w_take, ar_take, do_write;
   logic                 aw_held_d, w_held_d, bvalid_d, rvalid_d;
   logic                 lane0;
   logic [2:0]           tbt_q;
   logic [7:0]           ext_q;
   logic [IRQ_W-1:0]     stat_q, mask_q, stat_set, stat_clr;
   logic                 irq_q, heartbeat_en_q, jabber_en_q, nonstop_q;
   logic                 pattern_send_q;
   pattern_e             pattern_kind_q;
   pattern_cfg_s         cfg;
   logic [CNT_W-1:0]     err_count;
   logic                 err_at_max;
   gen_state_e           state_q, state_d;
   logic                 tmr_load, tmr_zero;
   logic [TIMER_W-1:0]   tmr_val, tmr_count, gap_cyc;
   logic                 seq_done;
   logic                 mapped_r;
   logic [31:0]          rd_word;

   // Handshake terms of the write and read channels
   assign aw_take   = awvalid && awready_q;
   assign w_take    = wvalid && wready_q;
   assign ar_take   = arvalid && arready_q;
   assign do_write  = aw_held_q && w_held_q && !bvalid_q;
   assign aw_held_d = (aw_held_q || aw_take) && !do_write;
   assign w_held_d  = (w_held_q || w_take) && !do_write;
   assign bvalid_d  = do_write || (bvalid_q && !bready);
   assign rvalid_d  = ar_take || (rvalid_q && !rready);
   assign lane0     = w_strb_q[0];

   // Address and data are caught in either order; one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q  <= w_held_d;
         awready_q <= !aw_held_d && !bvalid_d;
         wready_q  <= !w_held_d && !bvalid_d;
         if (aw_take) begin
            aw_addr_q <= awaddr;
         end
         if (w_take) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else begin
         bvalid_q <= bvalid_d;
         if (do_write) begin
            bresp_q <= (aw_addr_q == ADDR_TBT || aw_addr_q == ADDR_EXT || aw_addr_q == ADDR_STAT ||
                        aw_addr_q == ADDR_MASK) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Read data selection; bits above each register's width and unmapped addresses read as zero
   always_comb begin
      mapped_r = 1'b1;
      rd_word  = 32'h0000_0000;
      case (araddr)
         ADDR_TBT:  rd_word[2:0]  = tbt_q;
         ADDR_EXT:  rd_word[15:0] = {err_count, ext_q};
         ADDR_STAT: rd_word[IRQ_W-1:0] = stat_q;
         ADDR_MASK: rd_word[IRQ_W-1:0] = mask_q;
         default:   mapped_r = 1'b0;
      endcase
   end

   // Read channel; one read at a time, answered one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else begin
         rvalid_q  <= rvalid_d;
         arready_q <= !rvalid_d;
         if (ar_take) begin
            rdata_q <= rd_word;
            rresp_q <= mapped_r ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // 10BASE-T control bits: jabber disable, heartbeat disable, reserved one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tbt_q <= TBT_RESET;
      end else if (do_write && aw_addr_q == ADDR_TBT && lane0) begin
         tbt_q <= w_data_q[2:0];
      end
   end

   // Test extension control bits 7:0; the counter byte is read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_q <= EXT_RESET;
      end else if (do_write && aw_addr_q == ADDR_EXT && lane0) begin
         ext_q <= w_data_q[7:0];
      end
   end

   // Interrupt mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= IRQ_RESET;
      end else if (do_write && aw_addr_q == ADDR_MASK && lane0) begin
         mask_q <= w_data_q[IRQ_W-1:0];
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   assign stat_set[IRQ_SAT_BIT] = nibble_error && !selftest_restart && (err_count == CNT_W'(2**CNT_W - 2));
   assign stat_set[IRQ_ERR_BIT] = nibble_error && !selftest_restart;
   assign stat_set[IRQ_SEQ_BIT] = seq_done;
   assign stat_clr = (do_write && aw_addr_q == ADDR_STAT && lane0) ? w_data_q[IRQ_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= IRQ_RESET;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
         irq_q  <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
      end
   end

   // Self-test nibble error counter: cleared on restart, sticks at all ones
   sat_counter #(.W(CNT_W)) u_err_cnt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clr     (selftest_restart),
      .inc     (nibble_error),
      .count   (err_count),
      .at_max  (err_at_max)
   );

   // Line function enables decoded from speed, duplex and control bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         heartbeat_en_q <= 1'b0;
         jabber_en_q    <= 1'b0;
         nonstop_q      <= 1'b0;
      end else begin
         heartbeat_en_q <= !speed_100 && !full_duplex && !tbt_q[HB_DIS_BIT];
         jabber_en_q    <= !speed_100 && !tbt_q[JAB_DIS_BIT];
         nonstop_q      <= ext_q[NONSTOP_BIT];
      end
   end

   // Pattern configuration view of the extension bits
   assign cfg.ten_meg_pattern_on = ext_q[PATT_ON_BIT];
   assign cfg.pattern_gap_select = ext_q[GAP_SEL_BIT];
   assign cfg.pattern_choice     = pattern_e'(ext_q[CHOICE_LSB +: 2]);
   assign gap_cyc = cfg.pattern_gap_select ? TIMER_W'(GAP_LONG_CYC) : TIMER_W'(GAP_SHORT_CYC);

   // Sequence and gap generator; constant ones run with no gap
   always_comb begin
      state_d  = state_q;
      tmr_load = 1'b0;
      tmr_val  = TIMER_W'(SEQ_CYC - 1);
      seq_done = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (cfg.ten_meg_pattern_on) begin
               state_d  = ST_SEND;
               tmr_load = 1'b1;
            end
         end
         ST_SEND: begin
            if (!cfg.ten_meg_pattern_on) begin
               state_d = ST_IDLE;
            end else if (tmr_zero) begin
               tmr_load = 1'b1;
               if (cfg.pattern_choice != PAT_MANCHESTER_ONES) begin
                  state_d  = ST_GAP;
                  tmr_val  = gap_cyc - TIMER_W'(1);
                  seq_done = 1'b1;
               end
            end
         end
         ST_GAP: begin
            if (!cfg.ten_meg_pattern_on) begin
               state_d = ST_IDLE;
            end else if (tmr_zero) begin
               state_d  = ST_SEND;
               tmr_load = 1'b1;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   seq_timer #(.W(TIMER_W)) u_seq_tmr (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .count    (tmr_count),
      .zero     (tmr_zero)
   );

   // Generator state and its registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q        <= ST_IDLE;
         pattern_send_q <= 1'b0;
         pattern_kind_q <= PAT_DATA_END_FIRST;
      end else begin
         state_q        <= state_d;
         pattern_send_q <= (state_d == ST_SEND);
         if (cfg.ten_meg_pattern_on) begin
            pattern_kind_q <= cfg.pattern_choice;
         end
      end
   end

   // Outputs straight from flip-flops
   assign awready             = awready_q;
   assign wready              = wready_q;
   assign bvalid              = bvalid_q;
   assign bresp               = bresp_q;
   assign arready             = arready_q;
   assign rvalid              = rvalid_q;
   assign rdata               = rdata_q;
   assign rresp               = rresp_q;
   assign heartbeat_en        = heartbeat_en_q;
   assign jabber_en           = jabber_en_q;
   assign selftest_nonstop_tx = nonstop_q;
   assign pattern_send        = pattern_send_q;
   assign pattern_kind        = pattern_kind_q;
   assign irq                 = irq_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Heartbeat follows the disable bit only at 10 Mb half duplex
   property p_hb_half_10;
      (aresetn && !speed_100 && !full_duplex) |=> (heartbeat_en == !$past(tbt_q[HB_DIS_BIT]));
   endproperty
   a_hb_half_10: assert property (p_hb_half_10) else $error("heartbeat wrong at 10M half duplex");

   // Heartbeat off at 100 Mb or full duplex whatever the bit says
   property p_hb_forced_off;
      (speed_100 || full_duplex) |=> !heartbeat_en;
   endproperty
   a_hb_forced_off: assert property (p_hb_forced_off) else $error("heartbeat on at 100M or FD");

   // Jabber protection follows its disable bit at 10 Mb
   property p_jabber;
      (aresetn && !speed_100) |=> (jabber_en == !$past(tbt_q[JAB_DIS_BIT]));
   endproperty
   a_jabber: assert property (p_jabber) else $error("jabber enable wrong at 10M");

   // An error below saturation raises the count by exactly one
   property p_err_count;
      (nibble_error && !selftest_restart && !err_at_max) |=> (err_count == $past(err_count) + CNT_W'(1));
   endproperty
   a_err_count: assert property (p_err_count) else $error("error count did not advance");

   // Restart clears; a full count stays full under more errors
   property p_err_clear_sat;
      (selftest_restart |=> err_count == '0) and
      ((err_at_max && !selftest_restart) |=> err_at_max);
   endproperty
   a_err_clear_sat: assert property (p_err_clear_sat) else $error("error count clear or sticking wrong");

   // Continuous transmit output tracks its control bit one cycle later
   property p_nonstop;
      ##1 (selftest_nonstop_tx == $past(ext_q[NONSTOP_BIT]));
   endproperty
   a_nonstop: assert property (p_nonstop) else $error("nonstop transmit does not follow bit 5");

   // No pattern is sent while the enable has been clear for two cycles
   property p_pattern_off;
      (!cfg.ten_meg_pattern_on [*2]) |-> !pattern_send;
   endproperty
   a_pattern_off: assert property (p_pattern_off) else $error("pattern sent while disabled");

   // A gap starts with the count for the selected gap length
   property p_gap_len;
      (state_q == ST_SEND && state_d == ST_GAP) |=>
         (tmr_count == ($past(cfg.pattern_gap_select) ? TIMER_W'(GAP_LONG_CYC - 1) : TIMER_W'(GAP_SHORT_CYC - 1)));
   endproperty
   a_gap_len: assert property (p_gap_len) else $error("gap length does not match selection");

   // Constant ones never enter a gap: a sending cycle with that choice is not followed by one
   property p_ones_no_gap;
      (state_q == ST_SEND && cfg.pattern_choice == PAT_MANCHESTER_ONES) |=> (state_q != ST_GAP);
   endproperty
   a_ones_no_gap: assert property (p_ones_no_gap) else $error("gap inserted in constant ones");
endmodule : phy_10m_test_and_bist_ctrl

// *** src/phy_test_pkg.sv ***
// Shared constants and types of the PHY test and self-test control block
package phy_test_pkg;
   // Clock rate and the two pattern gap times
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
   localparam int unsigned GAP_SHORT_NS  = 10_000;
   localparam int unsigned GAP_LONG_NS   = 15_000;
   localparam int unsigned GAP_SHORT_CYC = (GAP_SHORT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned GAP_LONG_CYC  = (GAP_LONG_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SEQ_CYC_DEF   = 64;
   localparam int unsigned TIMER_W       = 10;

   // Register indices; byte address is four times the index
   localparam logic [7:0] TBT_IDX       = 8'h1A;
   localparam logic [7:0] EXT_IDX       = 8'h1B;
   localparam logic [7:0] IRQ_STAT_IDX  = 8'h20;
   localparam logic [7:0] IRQ_MASK_IDX  = 8'h21;

   // Field positions
   localparam int unsigned JAB_DIS_BIT   = 0;
   localparam int unsigned HB_DIS_BIT    = 1;
   localparam int unsigned TBT_RSV_BIT   = 2;
   localparam int unsigned CHOICE_LSB    = 0;
   localparam int unsigned GAP_SEL_BIT   = 2;
   localparam int unsigned PATT_ON_BIT   = 4;
   localparam int unsigned NONSTOP_BIT   = 5;
   localparam int unsigned ERRCNT_LSB    = 8;
   localparam int unsigned IRQ_SAT_BIT   = 0;
   localparam int unsigned IRQ_ERR_BIT   = 1;
   localparam int unsigned IRQ_SEQ_BIT   = 2;
   localparam int unsigned IRQ_W         = 3;

   // Values after reset
   localparam logic [2:0]  TBT_RESET     = 3'h4;
   localparam logic [7:0]  EXT_RESET     = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // Pattern choice encodings
   typedef enum logic [1:0] {
      PAT_DATA_END_FIRST  = 2'h0,
      PAT_DATA_END_SECOND = 2'h1,
      PAT_LINK_PULSES     = 2'h2,
      PAT_MANCHESTER_ONES = 2'h3
   } pattern_e;

   // Pattern generator configuration
   typedef struct packed {
      logic     ten_meg_pattern_on;
      logic     pattern_gap_select;
      pattern_e pattern_choice;
   } pattern_cfg_s;
endpackage : phy_test_pkg

// *** src/sat_counter.sv ***
// Saturating event counter with synchronous clear
`timescale 1ns/1ns
module sat_counter #(
   parameter int unsigned W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         clr,
   input  wire logic         inc,
   output logic [W-1:0]      count,
   output logic              at_max
);
   logic [W-1:0] count_q;

   // Clear has priority; the count sticks at all ones
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         count_q <= '0;
      end else if (inc && !at_max) begin
         count_q <= count_q + W'(1);
      end
   end

   assign count  = count_q;
   assign at_max = &count_q;
endmodule : sat_counter

// *** src/seq_timer.sv ***
// Loadable down counter that marks when it has run out
`timescale 1ns/1ns
module seq_timer #(
   parameter int unsigned W = 10
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic [W-1:0]      count,
   output logic              zero
);
   logic [W-1:0] count_q;

   // Load wins; otherwise count down to zero and stay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= load_val;
      end else if (count_q != '0) begin
         count_q <= count_q - W'(1);
      end
   end

   assign count = count_q;
   assign zero  = (count_q == '0);
endmodule : seq_timer

// *** sim/mgmt_master.sv ***
// Management station model: AXI4-Lite master issuing one register access at a time
`timescale 1ns/1ns
module mgmt_master (
   input  wire logic        aclk,
   output logic [7:0]       awaddr,
   output logic [2:0]       awprot,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [7:0]       araddr,
   output logic [2:0]       arprot,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   // Idle bus from time zero
   initial begin
      {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arprot, arvalid, rready} = '0;
   end

   // Write: address and data offered together, each released at its own handshake
   task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp, output bit ok);
      ok = 1'b0;
      resp = 2'h3;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            resp = bresp;
            ok = 1'b1;
         end
      end
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      bready  <= 1'b0;
   endtask : write

   // Read: address held until taken, data taken at the edge rvalid is seen
   task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp, output bit ok);
      ok = 1'b0;
      resp = 2'h3;
      d = '0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            resp = rresp;
            ok = 1'b1;
         end
      end
      arvalid <= 1'b0;
      rready  <= 1'b0;
   endtask : read
endmodule : mgmt_master

// *** sim/tb_top.sv ***
// Self-checking bench of the PHY test and self-test control block
`timescale 1ns/1ns
module tb_top
   import phy_test_pkg::*;
;
   localparam logic [7:0] A_TBT = 8'h68, A_EXT = 8'h6C, A_STAT = 8'h80, A_MASK = 8'h84;
   localparam int         SEQ_N = 4;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, speed_100, full_duplex;
   logic        selftest_restart, nibble_error, heartbeat_en, jabber_en, selftest_nonstop_tx, pattern_send, irq;
   logic [7:0]  awaddr, araddr;
   logic [2:0]  awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   pattern_e    pattern_kind;
   int          mismatches, checked;

   phy_10m_test_and_bist_ctrl #(.SEQ_CYC(SEQ_N), .CNT_W(8)) u_phy_10m_test_and_bist_ctrl (.aclk, .aresetn,
      .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .speed_100, .full_duplex,
      .selftest_restart, .nibble_error, .heartbeat_en, .jabber_en, .selftest_nonstop_tx, .pattern_send,
      .pattern_kind, .irq);
   mgmt_master u_mgmt_master (.aclk, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

   // 25 MHz clock
   always #20 aclk = ~aclk;

   task automatic stop_test();
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic hang(input bit ok);
      if (!ok) begin
         mismatches++;
         $display("wrong value at %0t: bus access timed out", $time);
         stop_test();
      end
   endtask : hang

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      bit         ok;
      u_mgmt_master.write(a, d, r, ok);
      hang(ok);
      chk(32'(r), 32'(er), "write response");
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      bit         ok;
      u_mgmt_master.read(a, d, r, ok);
      hang(ok);
      chk(32'(r), 32'(er), "read response");
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // Nibble error line held high for n cycles, one event per cycle
   task automatic pulse(input int n);
      @(posedge aclk) nibble_error <= 1'b1;
      tick(n);
      nibble_error <= 1'b0;
   endtask : pulse

   // Cycles that pattern_send keeps one level, up to a cap
   task automatic measure(input logic lvl, input int cap, output int n);
      n = 0;
      while (pattern_send === lvl && n < cap) begin
         @(posedge aclk);
         n++;
      end
   endtask : measure

   task automatic t_reset();
      logic [31:0] d;
      rd(A_TBT, d, RESP_OKAY);
      chk(d, 32'(TBT_RESET), "control reset value");
      rd(A_EXT, d, RESP_OKAY);
      chk(d, 32'h0, "extension reset value");
      rd(A_MASK, d, RESP_OKAY);
      chk(d, 32'h0, "mask reset value");
      chk(heartbeat_en, 1'b1, "heartbeat after reset");
      chk(jabber_en, 1'b1, "jabber after reset");
      chk(pattern_send, 1'b0, "pattern idle after reset");
      rd(8'h10, d, RESP_SLVERR);
      chk(d, 32'h0, "unmapped read data");
      wr(8'h10, 32'h1, RESP_SLVERR);
   endtask : t_reset

   // Every speed, duplex and disable combination
   task automatic t_link();
      logic [31:0] d;
      for (int i = 0; i < 16; i++) begin
         speed_100   <= i[3];
         full_duplex <= i[2];
         wr(A_TBT, 32'(4 + 2 * i[1] + i[0]), RESP_OKAY);
         tick(2);
         chk(heartbeat_en, !i[3] && !i[2] && !i[1], "heartbeat");
         chk(jabber_en, !i[3] && !i[0], "jabber");
         rd(A_TBT, d, RESP_OKAY);
         chk(d, 32'(4 + 2 * i[1] + i[0]), "control readback");
      end
      speed_100   <= 1'b0;
      full_duplex <= 1'b0;
   endtask : t_link

   task automatic t_nonstop();
      wr(A_TBT, 32'h5, RESP_OKAY);
      wr(A_EXT, 32'h20, RESP_OKAY);
      tick(2);
      chk(selftest_nonstop_tx, 1'b1, "nonstop on");
      chk(jabber_en, 1'b0, "jabber off for nonstop");
      wr(A_EXT, 32'h0, RESP_OKAY);
      tick(2);
      chk(selftest_nonstop_tx, 1'b0, "nonstop off");
      wr(A_TBT, 32'h4, RESP_OKAY);
   endtask : t_nonstop

   task automatic t_errors();
      logic [31:0] d;
      @(posedge aclk) selftest_restart <= 1'b1;
      @(posedge aclk) selftest_restart <= 1'b0;
      pulse(3);
      rd(A_EXT, d, RESP_OKAY);
      chk(d, 32'h0300, "error count");
      chk(irq, 1'b0, "masked interrupt");
      rd(A_STAT, d, RESP_OKAY);
      chk(d, 32'h2, "error flag");
      wr(A_MASK, 32'h2, RESP_OKAY);
      tick(2);
      chk(irq, 1'b1, "unmasked interrupt");
      wr(A_STAT, 32'h2, RESP_OKAY);
      tick(2);
      chk(irq, 1'b0, "cleared interrupt");
      pulse(300);
      wr(A_EXT, 32'h0, RESP_OKAY); // Count field ignores writes
      rd(A_EXT, d, RESP_OKAY);
      chk(d, 32'hFF00, "saturated count");
      rd(A_STAT, d, RESP_OKAY);
      chk(d, 32'h3, "saturation flag");
      // Restart wins over a coincident error
      @(posedge aclk) selftest_restart <= 1'b1;
      nibble_error <= 1'b1;
      @(posedge aclk) selftest_restart <= 1'b0;
      nibble_error <= 1'b0;
      rd(A_EXT, d, RESP_OKAY);
      chk(d, 32'h0, "count after restart");
      wr(A_STAT, 32'h7, RESP_OKAY);
      wr(A_MASK, 32'h0, RESP_OKAY);
   endtask : t_errors

   // All four choices; gap select follows the low choice bit
   task automatic t_pattern();
      int          n;
      logic [31:0] d;
      for (int c = 0; c < 4; c++) begin
         wr(A_EXT, 32'(16 + c + 4 * (c % 2)), RESP_OKAY);
         tick(3);
         chk(32'(pattern_kind), 32'(c), "pattern kind");
         measure(1'b1, 1000, n);
         measure(1'b0, 1000, n);
         if (c < 3) begin
            measure(1'b1, 1000, n);
            chk(n, SEQ_N, "sequence length");
            measure(1'b0, 1000, n);
            chk(n, (c % 2) ? GAP_LONG_CYC : GAP_SHORT_CYC, "gap length");
         end else begin
            measure(1'b1, 600, n);
            chk(n, 600, "constant ones");
         end
      end
      wr(A_EXT, 32'h1, RESP_OKAY);
      tick(3);
      chk(pattern_send, 1'b0, "pattern disabled");
      chk(32'(pattern_kind), 32'h3, "choice ignored while off");
      rd(A_STAT, d, RESP_OKAY);
      chk(d, 32'h4, "sequence finished flag");
      wr(A_STAT, 32'h4, RESP_OKAY);
      rd(A_STAT, d, RESP_OKAY);
      chk(d, 32'h0, "sequence flag cleared");
   endtask : t_pattern

   // Reset, then the scenarios in turn
   initial begin
      {aclk, aresetn, speed_100, full_duplex, selftest_restart, nibble_error} = '0;
      mismatches = 0;
      checked = 0;
      tick(5);
      aresetn <= 1'b1;
      t_reset();
      t_link();
      t_nonstop();
      t_errors();
      t_pattern();
      stop_test();
   end
endmodule : tb_top
